// file: src/ucaf_regs.sv
// Operation
// R1: Pingpong reset returns pointers to even bank.
// R2: Device mode bit 0 enables module.
// R3: Host mode bit 0 sends SOF each 1ms.
// R4: Software waits token idle before new token.
// R5: Host enable toggle resets host logic.
// R6: Software holds resume 10ms or 25ms.
// R7: Host resume clear appends low-speed EOP.
// R8: Address bit 7 selects low speed token.
// R9: Address bits 6:0 hold device address.
// R10: Frame low register shows bits 7:0.
// R11: Frame high register shows bits 10:8.
// R12: Received SOF loads frame number registers.
// R13: Token register holds PID and endpoint.
// R14: PID codes OUT, IN, SETUP only.
// R15: Busy flag shows token in execution.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ucaf_regs #(
  parameter int FRAME_CYCLES = ucaf_pkg::UCAF_FRAME_CYCLES
) (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Link engine side
  input  wire logic                    sof_rx,
  input  wire logic [10:0]             sof_rx_frame,
  input  wire logic                    token_done,
  output logic                         module_enable_bit,
  output logic                         pingpong_pointer_reset,
  output logic                         host_logic_reset,
  output logic                         sof_tx,
  output logic                         resume_drive,
  output logic                         ls_eop_tx,
  output logic                         token_start,
  output ucaf_pkg::ucaf_token_s        token_out,
  output ucaf_pkg::ucaf_address_s      address_out
);
  import ucaf_pkg::*;

  logic [7:0]    ctrl;
  ucaf_address_s addr_q;
  ucaf_token_s   tok_q;
  logic [10:0]   frame;
  logic          token_in_progress;
  logic [31:0]   sof_cnt;
  logic [31:0]   sof_gap;
  logic          aw_held;
  logic          w_held;
  logic [7:0]    aw_q;
  logic [31:0]   w_q;
  logic [3:0]    ws_q;

  wire host_mode    = ctrl[UCAF_BIT_HOST];
  wire aw_take      = s_axi_awvalid && s_axi_awready;
  wire w_take       = s_axi_wvalid && s_axi_wready;
  wire [7:0]  wa    = aw_held ? aw_q : s_axi_awaddr;
  wire [31:0] wd    = w_held ? w_q : s_axi_wdata;
  wire [3:0]  wsb   = w_held ? ws_q : s_axi_wstrb;
  wire have_aw      = aw_held || aw_take;
  wire have_w       = w_held || w_take;
  wire do_write     = have_aw && have_w && !s_axi_bvalid;
  wire wr_lane0     = do_write && wsb[0];
  wire wr_ctrl      = wr_lane0 && wa == UCAF_OFS_CONTROL;
  wire wr_addr      = wr_lane0 && wa == UCAF_OFS_ADDRESS;
  wire wr_tok       = wr_lane0 && wa == UCAF_OFS_TOKEN;
  wire wa_mapped    = wa == UCAF_OFS_CONTROL || wa == UCAF_OFS_ADDRESS ||
                      wa == UCAF_OFS_TOKEN || wa == UCAF_OFS_FRM_LOW ||
                      wa == UCAF_OFS_FRM_HIGH;
  wire [7:0] next_ctrl = {2'b00, 1'b0, wd[4:0]};
  wire host_toggle  = wr_ctrl && (next_ctrl[UCAF_BIT_HOST] != host_mode);
  wire resume_fall  = wr_ctrl && ctrl[UCAF_BIT_RESUME] &&
                      !next_ctrl[UCAF_BIT_RESUME];
  wire sof_wrap     = sof_cnt >= 32'(FRAME_CYCLES - 1);
  wire sof_hold     = host_toggle || !host_mode ||
                      !ctrl[UCAF_BIT_ENABLE];
  wire ar_take      = s_axi_arvalid && s_axi_arready;
  wire [7:0] busy_b = {2'b00, host_mode && token_in_progress, 5'h00};
  wire [7:0] ctrl_rd = ctrl | busy_b;
  wire ra_mapped    = s_axi_araddr == UCAF_OFS_CONTROL ||
                      s_axi_araddr == UCAF_OFS_ADDRESS ||
                      s_axi_araddr == UCAF_OFS_FRM_LOW ||
                      s_axi_araddr == UCAF_OFS_FRM_HIGH ||
                      s_axi_araddr == UCAF_OFS_TOKEN;
  wire [7:0] rd_byte =
    s_axi_araddr == UCAF_OFS_CONTROL  ? ctrl_rd :
    s_axi_araddr == UCAF_OFS_ADDRESS  ? addr_q :
    s_axi_araddr == UCAF_OFS_FRM_LOW  ? frame[7:0] :
    s_axi_araddr == UCAF_OFS_FRM_HIGH ? {5'h00, frame[10:8]} :
    s_axi_araddr == UCAF_OFS_TOKEN    ? tok_q : 8'h00;

  // Write channels are taken independently and joined before the answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end else begin
      aw_held <= have_aw && !do_write;
      w_held  <= have_w && !do_write;
      if (aw_take) aw_q <= s_axi_awaddr;
      if (w_take) begin
        w_q  <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= UCAF_RESP_OKAY;
    end else begin
      s_axi_awready <= !(have_aw) && !s_axi_bvalid && !do_write;
      s_axi_wready  <= !(have_w) && !s_axi_bvalid && !do_write;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_mapped ? UCAF_RESP_OKAY : UCAF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= UCAF_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= ra_mapped ? UCAF_RESP_OKAY : UCAF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // R9 address field
  // R8 slow speed flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl   <= UCAF_RST_CONTROL;
      addr_q <= UCAF_RST_ADDRESS;
    end else begin
      if (wr_ctrl) ctrl <= next_ctrl;
      if (wr_addr) addr_q <= wd[7:0];
    end
  end

  // R13 token fields
  // R14 reserved PID codes are not started
  // R4 a write while busy is dropped
  // R15 busy tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tok_q             <= UCAF_RST_TOKEN;
      token_in_progress <= 1'b0;
      token_start       <= 1'b0;
    end else begin
      token_start <= 1'b0;
      if (host_toggle) begin
        token_in_progress <= 1'b0;
      end else if (wr_tok && !token_in_progress) begin
        tok_q <= wd[7:0];
        if (host_mode && (wd[7:4] == UCAF_PID_OUT ||
            wd[7:4] == UCAF_PID_IN || wd[7:4] == UCAF_PID_SETUP)) begin
          token_in_progress <= 1'b1;
          token_start       <= 1'b1;
        end
      end else if (token_done) begin
        token_in_progress <= 1'b0;
      end
    end
  end

  // R10 R11 R12 frame capture
  always_ff @(posedge aclk) begin
    if (!aresetn) frame <= UCAF_RST_FRAME;
    else if (sof_rx) frame <= sof_rx_frame;
  end

  // R3 frame marker timer
  // R5 host reset restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn || sof_hold) begin
      sof_cnt <= 32'h0000_0000;
      sof_tx  <= 1'b0;
    end else begin
      sof_cnt <= sof_wrap ? 32'h0000_0000 : sof_cnt + 32'h0000_0001;
      sof_tx  <= sof_wrap;
    end
  end

  // R3 marker spacing watch
  // Checker-only counter, kept apart from the timer it watches.
  always_ff @(posedge aclk) begin
    if (!aresetn || sof_hold) begin
      sof_gap <= 32'h0000_0000;
    end else begin
      sof_gap <= sof_tx ? 32'h0000_0001 : sof_gap + 32'h0000_0001;
    end
  end

  // R1 R2 R5 R7 control outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_enable_bit      <= 1'b0;
      pingpong_pointer_reset <= 1'b0;
      host_logic_reset       <= 1'b0;
      resume_drive           <= 1'b0;
      ls_eop_tx              <= 1'b0;
      token_out              <= UCAF_RST_TOKEN;
      address_out            <= UCAF_RST_ADDRESS;
    end else begin
      module_enable_bit      <= !host_mode && ctrl[UCAF_BIT_ENABLE];
      pingpong_pointer_reset <= ctrl[UCAF_BIT_PPRST];
      host_logic_reset       <= host_toggle;
      resume_drive           <= ctrl[UCAF_BIT_RESUME];
      ls_eop_tx              <= resume_fall && host_mode;
      token_out              <= tok_q;
      address_out            <= addr_q;
    end
  end

  // R12 frame follows received SOF
  frame_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    sof_rx |=> frame == $past(sof_rx_frame))
    else $error("frame not loaded from SOF");
  // R15 busy set in the same cycle as token start
  busy_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    token_start |-> token_in_progress)
    else $error("busy missing after token start");
  // R7 EOP after resume clear in host mode
  eop_after_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    (resume_fall && host_mode) |=> ls_eop_tx)
    else $error("missing low speed EOP");
  // R3 no SOF outside host mode
  sof_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    !host_mode |=> !sof_tx)
    else $error("SOF outside host mode");
  // R5 host reset on toggle
  host_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    host_toggle |=> host_logic_reset && !token_in_progress)
    else $error("host logic not reset on toggle");
  // R1 pointer reset follows bit
  pp_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    ctrl[UCAF_BIT_PPRST] |=> pingpong_pointer_reset)
    else $error("pingpong reset not driven");
  // R2 enable in device mode
  dev_enable_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (!host_mode && ctrl[UCAF_BIT_ENABLE]) |=> module_enable_bit)
    else $error("module enable not driven");
  // R9 address write stored
  addr_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    wr_addr |=> addr_q == $past(wd[7:0]))
    else $error("address write lost");
  // R8 slow flag reaches output
  slow_out_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    addr_q.slow |=> address_out.slow)
    else $error("slow flag not presented");
  // R1 pointer reset released
  pp_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    !ctrl[UCAF_BIT_PPRST] |=> !pingpong_pointer_reset)
    else $error("pingpong reset stuck");
  // R2 module off in host mode
  host_dev_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    host_mode |=> !module_enable_bit)
    else $error("module enable in host mode");
  // R3 marker period
  sof_period_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    sof_tx |-> sof_gap == 32'(FRAME_CYCLES))
    else $error("frame marker period wrong");
  // R3 no marker missed
  sof_gap_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    sof_gap <= 32'(FRAME_CYCLES))
    else $error("frame marker missing");
  // R7 EOP only as host
  eop_host_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    ls_eop_tx |-> $past(host_mode))
    else $error("low speed EOP outside host mode");
  // R10 frame low read
  frm_low_rd_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    ar_take && s_axi_araddr == UCAF_OFS_FRM_LOW |=>
      s_axi_rdata == {24'h00_0000, $past(frame[7:0])})
    else $error("frame low read wrong");
  // R10 upper bits zero
  upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  // R11 frame high read
  high_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    ar_take && s_axi_araddr == UCAF_OFS_FRM_HIGH |=>
      s_axi_rdata == {29'h0, $past(frame[10:8])})
    else $error("frame high read wrong");
  // R12 frame held between markers
  frame_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    !sof_rx |=> frame == $past(frame))
    else $error("frame changed without SOF");
  // R13 token write stored
  tok_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    wr_tok && !token_in_progress |=> tok_q == $past(wd[7:0]))
    else $error("token write lost");
  // R4 busy token write dropped
  tok_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    wr_tok && token_in_progress |=> tok_q == $past(tok_q))
    else $error("token overwritten while busy");
  // R14 only valid codes start
  pid_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    token_start |-> tok_q.pid == UCAF_PID_OUT || tok_q.pid == UCAF_PID_IN ||
      tok_q.pid == UCAF_PID_SETUP)
    else $error("reserved token code started");
  // R15 busy ends on done
  busy_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    token_in_progress && token_done |=> !token_in_progress)
    else $error("busy not cleared by done");
  // R15 busy bit readable
  busy_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    ar_take && s_axi_araddr == UCAF_OFS_CONTROL |=>
      s_axi_rdata[UCAF_BIT_BUSY] == ($past(host_mode) &&
      $past(token_in_progress)))
    else $error("busy bit read wrong");
endmodule
`default_nettype wire

// file: src/ucaf_pkg.sv
package ucaf_pkg;
  localparam logic [7:0] UCAF_OFS_CONTROL  = 8'h00;
  localparam logic [7:0] UCAF_OFS_ADDRESS  = 8'h04;
  localparam logic [7:0] UCAF_OFS_FRM_LOW  = 8'h08;
  localparam logic [7:0] UCAF_OFS_FRM_HIGH = 8'h0C;
  localparam logic [7:0] UCAF_OFS_TOKEN    = 8'h10;
  localparam int UCAF_BIT_ENABLE  = 0;
  localparam int UCAF_BIT_PPRST   = 1;
  localparam int UCAF_BIT_RESUME  = 2;
  localparam int UCAF_BIT_HOST    = 3;
  localparam int UCAF_BIT_BUSY    = 5;
  localparam int UCAF_BIT_SLOW    = 7;
  localparam logic [7:0] UCAF_RST_CONTROL = 8'h00;
  localparam logic [7:0] UCAF_RST_ADDRESS = 8'h00;
  localparam logic [7:0] UCAF_RST_TOKEN   = 8'h00;
  localparam logic [10:0] UCAF_RST_FRAME  = 11'h000;
  localparam logic [3:0] UCAF_PID_OUT   = 4'h1;
  localparam logic [3:0] UCAF_PID_IN    = 4'h9;
  localparam logic [3:0] UCAF_PID_SETUP = 4'hD;
  localparam int UCAF_CLK_HZ       = 50000000;
  localparam int UCAF_FRAME_US     = 1000;
  localparam int UCAF_FRAME_CYCLES = UCAF_CLK_HZ / 1000000 * UCAF_FRAME_US;
  localparam logic [1:0] UCAF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UCAF_RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [3:0] pid;
    logic [3:0] endpoint;
  } ucaf_token_s;
  typedef struct packed {
    logic       slow;
    logic [6:0] addr;
  } ucaf_address_s;
endpackage

// file: testbench/ucaf_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucaf_link_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench control
  input  wire logic        sof_req,
  input  wire logic [10:0] sof_val,
  input  wire logic [7:0]  delay,
  // Register block side
  input  wire logic        token_start,
  output logic             sof_rx,
  output logic [10:0]      sof_rx_frame,
  output logic             token_done
);
  logic [7:0]  left;
  logic        busy;
  logic [10:0] last;
  // The frame lines toggle between frames so a stale number never passes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sof_rx       <= 1'b0;
      sof_rx_frame <= 11'h000;
      last         <= 11'h000;
      token_done   <= 1'b0;
      busy         <= 1'b0;
      left         <= 8'h00;
    end else begin
      sof_rx       <= sof_req;
      sof_rx_frame <= sof_req ? sof_val : ~last;
      last         <= sof_req ? sof_val : ~last;
      token_done   <= 1'b0;
      if (token_start) begin
        busy <= 1'b1;
        left <= delay;
      end else if (busy && left == 8'h00) begin
        busy       <= 1'b0;
        token_done <= 1'b1;
      end else if (busy) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/usb_control_address_frame_token_test.sv
`timescale 1ns/1ps
`default_nettype none
module usb_control_address_frame_token_test;
  import ucaf_pkg::*;
  localparam int FC = 20;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, sof_rx, token_done;
  logic sof_req, module_enable_bit, pingpong_pointer_reset, sof_tx;
  logic host_logic_reset, resume_drive, ls_eop_tx, token_start;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, delay;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, ep;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [10:0] sof_rx_frame, sof_val, f;
  ucaf_token_s   token_out;
  ucaf_address_s address_out;
  logic [3:0] pids [4] = '{UCAF_PID_OUT, UCAF_PID_IN, UCAF_PID_SETUP, 4'h3};
  int failures = 0, num_checks = 0, n_sof = 0, n_hl = 0, n_eop = 0;
  int n_go = 0, i, k, s;
  ucaf_regs #(.FRAME_CYCLES(FC)) ucaf_regs_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sof_rx, .sof_rx_frame, .token_done,
    .module_enable_bit, .pingpong_pointer_reset, .host_logic_reset,
    .sof_tx, .resume_drive, .ls_eop_tx, .token_start, .token_out,
    .address_out);
  ucaf_link_model ucaf_link_model_i (.aclk, .aresetn, .sof_req, .sof_val,
    .delay, .token_start, .sof_rx, .sof_rx_frame, .token_done);
  always @(posedge aclk) begin
    n_sof <= n_sof + int'(sof_tx === 1'b1);
    n_hl  <= n_hl + int'(host_logic_reset === 1'b1);
    n_eop <= n_eop + int'(ls_eop_tx === 1'b1);
    n_go  <= n_go + int'(token_start === 1'b1);
  end
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic int pid_ok(input logic [3:0] p);
    return int'(p == UCAF_PID_OUT || p == UCAF_PID_IN ||
                p == UCAF_PID_SETUP);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin
      failures++;
      stop_test();
    end
    chk("write response", 32'(s_axi_bresp), 32'(UCAF_RESP_OKAY));
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  task automatic sof(input logic [10:0] v);
    @(posedge aclk);
    sof_req <= 1'b1;
    sof_val <= v;
    @(posedge aclk);
    sof_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, sof_req} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, sof_val, delay} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(52973));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("control", UCAF_OFS_CONTROL, 32'h0);
    rchk("address", UCAF_OFS_ADDRESS, 32'h0);
    rchk("frame low", UCAF_OFS_FRM_LOW, 32'h0);
    rchk("frame high", UCAF_OFS_FRM_HIGH, 32'h0);
    rchk("token", UCAF_OFS_TOKEN, 32'h0);
    rd(8'h14, d, r);
    chk("unmapped", 32'(r), 32'(UCAF_RESP_SLVERR));
    for (i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'h000000FF : 32'($urandom_range(255));
      wr(UCAF_OFS_ADDRESS, d);
      chk("slow", 32'(address_out.slow), 32'(d[7]));
      chk("fn addr", 32'(address_out.addr), 32'(d[6:0]));
      rchk("address", UCAF_OFS_ADDRESS, d);
    end
    s_axi_wstrb <= 4'h0;
    wr(UCAF_OFS_ADDRESS, 32'h0000_0011);
    s_axi_wstrb <= 4'hF;
    rchk("address", UCAF_OFS_ADDRESS, d);
    for (i = 0; i < 3; i++) begin
      f = (i == 0) ? 11'h7FF : 11'($urandom_range(2047));
      sof(f);
      rchk("frame low", UCAF_OFS_FRM_LOW, 32'(f[7:0]));
      rchk("frame high", UCAF_OFS_FRM_HIGH, 32'(f[10:8]));
    end
    wr(UCAF_OFS_FRM_LOW, 32'h00000055);
    rchk("frame low", UCAF_OFS_FRM_LOW, 32'(f[7:0]));
    wr(UCAF_OFS_CONTROL, 32'h00000003);
    chk("enable", 32'(module_enable_bit), 32'h1);
    chk("pingpong", 32'(pingpong_pointer_reset), 32'h1);
    wr(UCAF_OFS_CONTROL, 32'h00000000);
    chk("pingpong", 32'(pingpong_pointer_reset), 32'h0);
    s = n_hl;
    wr(UCAF_OFS_CONTROL, 32'h00000008);
    repeat (2) @(posedge aclk);
    chk("host reset", 32'(n_hl), 32'(s + 1));
    s = n_sof;
    repeat (5 * FC) @(posedge aclk);
    chk("no frames", 32'(n_sof), 32'(s));
    wr(UCAF_OFS_CONTROL, 32'h00000009);
    chk("enable host", 32'(module_enable_bit), 32'h0);
    repeat (5) @(posedge aclk);
    s = n_sof;
    repeat (5 * FC) @(posedge aclk);
    chk("frames", 32'(n_sof), 32'(s + 5));
    for (i = 0; i < 4; i++) begin
      ep = 4'($urandom_range(15));
      delay <= 8'(16 + $urandom_range(15));
      s = n_go;
      wr(UCAF_OFS_TOKEN, {24'h0, pids[i], ep});
      repeat (2) @(posedge aclk);
      chk("token out", 32'(token_out), {24'h0, pids[i], ep});
      chk("starts", 32'(n_go), 32'(s + pid_ok(pids[i])));
      if (pid_ok(pids[i]) == 1) begin
        rd(UCAF_OFS_CONTROL, d, r);
        chk("busy", 32'(d[UCAF_BIT_BUSY]), 32'h1);
        wr(UCAF_OFS_TOKEN, {24'h0, pids[i], ~ep});
        rchk("token", UCAF_OFS_TOKEN, {24'h0, pids[i], ep});
        k = 0;
        do begin
          rd(UCAF_OFS_CONTROL, d, r);
          k++;
        end while (d[UCAF_BIT_BUSY] !== 1'b0 && k < 20);
        chk("idle", 32'(d[UCAF_BIT_BUSY]), 32'h0);
      end
    end
    s = n_eop;
    wr(UCAF_OFS_CONTROL, 32'h0000000D);
    chk("resume", 32'(resume_drive), 32'h1);
    repeat (25 * FC) @(posedge aclk);
    wr(UCAF_OFS_CONTROL, 32'h00000009);
    repeat (2) @(posedge aclk);
    chk("end of packet", 32'(n_eop), 32'(s + 1));
    s = n_hl;
    wr(UCAF_OFS_CONTROL, 32'h00000001);
    repeat (2) @(posedge aclk);
    chk("host reset", 32'(n_hl), 32'(s + 1));
    chk("enable", 32'(module_enable_bit), 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
